// file: rtl/pbcs_map.vh
/*
  register map, field positions, reset values and timing counts for the
  base clock selector; assumes 32-bit AXI4-Lite data, one register per word
*/
`ifndef PBCS_MAP_VH
`define PBCS_MAP_VH

`define PBCS_ADDR_W        4
`define PBCS_OFF_CTRL      4'h0
`define PBCS_OFF_BW        4'h4
`define PBCS_OFF_PROG      4'h8

// control register fields
`define PBCS_CTL_IE        7
`define PBCS_CTL_FLAG      6
`define PBCS_CTL_PON       5
`define PBCS_CTL_SEL       4
`define PBCS_CTL_RSVD      4'hf

// bandwidth register fields
`define PBCS_BW_AUTO       7
`define PBCS_BW_LOCK       6
`define PBCS_BW_ACQ        5

// program register fields
`define PBCS_MUL_HI        7
`define PBCS_MUL_LO        4
`define PBCS_RNG_HI        3
`define PBCS_RNG_LO        0
`define PBCS_MUL_RST       4'h6
`define PBCS_RNG_RST       4'h6
`define PBCS_NIB_ZERO      4'h0
`define PBCS_NIB_ONE       4'h1

// source change: edges counted on each side
`define PBCS_SW_EDGES      2'h3

`define PBCS_RESP_OKAY     2'h0
`define PBCS_RESP_SLVERR   2'h2

`endif

// file: rtl/pbcs_top.v
/*
  base clock selector with register interface: picks crystal or vco clock,
  switches between them through a held transition, divides by two for the
  base clock and by four for the bus clock, and keeps the interlocks on the
  power-on, select and program fields.
  assumes both source clocks are slower than a quarter of clk_sys so that
  every edge is seen after synchronising; lock level comes from the analog
  lock detector; stop request is a clk_sys pulse from the integration logic.
  limitation: only a vco switched off during a change is timed by clk_sys cycles; a stopped crystal is waited on.
*/
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pbcs_map.vh"

module pbcs_top (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_b,
  // clock sources and analog status, asynchronous
  input  wire        crystal_ref_clock,
  input  wire        vco_clock,
  input  wire        pll_lock_in,
  input  wire        osc_enable_in,
  // integration logic, clk_sys domain
  input  wire        stop_req,
  output reg         base_clock_out,
  output reg         bus_clock_out,
  output reg         lock_irq_out,
  output reg         pll_enable_out,
  output reg  [3:0]  fb_divide_out,
  output reg  [3:0]  range_out,
  output reg         acq_track_out,
  // axi4-lite write
  input  wire [`PBCS_ADDR_W-1:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [`PBCS_ADDR_W-1:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_OLD  = 3'b010;
  localparam [2:0] ST_NEW  = 3'b100;

  reg        rst_m_r;
  reg        rst_s_r;
  wire       rst_n = rst_s_r;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  // a source edge reaches the counters three clk_sys later
  // synchronisers; stage 1 only feeds stage 2
  reg  [3:0] sync1_r;
  reg  [3:0] sync2_r;
  reg        xclk_d_r;
  reg        vclk_d_r;
  reg        lock_d_r;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r  <= 4'h0;
      sync2_r  <= 4'h0;
      xclk_d_r <= 1'b0;
      vclk_d_r <= 1'b0;
      lock_d_r <= 1'b0;
    end else begin
      sync1_r  <= {osc_enable_in, pll_lock_in, vco_clock, crystal_ref_clock};
      sync2_r  <= sync1_r;
      xclk_d_r <= sync2_r[0];
      vclk_d_r <= sync2_r[1];
      lock_d_r <= sync2_r[2];
    end
  end

  wire osc_en  = sync2_r[3];
  wire lock_s  = sync2_r[2];
  wire xclk_en = sync2_r[0] & ~xclk_d_r & osc_en;
  wire vclk_en = sync2_r[1] & ~vclk_d_r & pll_enable_out;

  // registers
  reg        pll_power_on_r;
  reg        base_source_select_r;
  reg        irq_enable_r;
  reg        lock_change_flag_r;
  reg        auto_bw_r;
  reg        acq_manual_r;
  reg  [3:0] mul_r;
  reg  [3:0] rng_r;

  wire       rng_zero = (rng_r == `PBCS_NIB_ZERO);

  // axi handshakes: address and data taken together, read answered one cycle later, write two cycles later
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  reg  [`PBCS_ADDR_W-1:0] awaddr_r;
  reg  [7:0] wbyte_r;
  reg        wlane_r;

  wire wr_ctl  = s_axi_awready & wlane_r & (awaddr_r == `PBCS_OFF_CTRL);
  wire wr_bw   = s_axi_awready & wlane_r & (awaddr_r == `PBCS_OFF_BW);
  wire wr_prg  = s_axi_awready & wlane_r & (awaddr_r == `PBCS_OFF_PROG);
  wire rd_ctl  = rd_go & (s_axi_araddr == `PBCS_OFF_CTRL);
  wire lock_tg = auto_bw_r & (lock_s ^ lock_d_r);
  // mapped offsets answer okay, the rest a slave error
  wire aw_hit  = (awaddr_r == `PBCS_OFF_CTRL) | (awaddr_r == `PBCS_OFF_BW) |
                 (awaddr_r == `PBCS_OFF_PROG);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PBCS_RESP_OKAY;
      awaddr_r      <= {`PBCS_ADDR_W{1'b0}};
      wbyte_r       <= 8'h00;
      wlane_r       <= 1'b0;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go) begin
        awaddr_r <= s_axi_awaddr;
        wbyte_r  <= s_axi_wdata[7:0];
        wlane_r  <= s_axi_wstrb[0];
      end
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_hit ? `PBCS_RESP_OKAY : `PBCS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PBCS_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `PBCS_RESP_OKAY;
        case (s_axi_araddr)
          `PBCS_OFF_CTRL: s_axi_rdata <= {24'h000000, irq_enable_r,
                                          lock_change_flag_r & auto_bw_r,
                                          pll_power_on_r, base_source_select_r,
                                          `PBCS_CTL_RSVD};
          `PBCS_OFF_BW:   s_axi_rdata <= {24'h000000, auto_bw_r, lock_s & auto_bw_r,
                                          acq_track_out, 5'h00};
          `PBCS_OFF_PROG: s_axi_rdata <= {24'h000000, mul_r, rng_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PBCS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // next values for the interlocked fields
  reg        pll_power_on_nxt;
  reg        base_source_select_nxt;
  reg        lock_change_flag_nxt;
  reg  [3:0] mul_nxt;
  reg  [3:0] rng_nxt;

  // power is frozen while the select field asks for the vco
  wire       pon_locked = base_source_select_r;
  // select needs power on before the write and kept on by it
  wire       sel_allow  = pll_power_on_r & wbyte_r[`PBCS_CTL_PON] & ~rng_zero;

  always @* begin
    pll_power_on_nxt       = pll_power_on_r;
    base_source_select_nxt = base_source_select_r;
    lock_change_flag_nxt   = lock_change_flag_r;
    mul_nxt                = mul_r;
    rng_nxt                = rng_r;
    if (wr_ctl) begin
      if (!pon_locked)
        pll_power_on_nxt = wbyte_r[`PBCS_CTL_PON];
      base_source_select_nxt = wbyte_r[`PBCS_CTL_SEL] & sel_allow;
    end
    // stop and a zero range override any write in the same cycle
    if (stop_req || rng_zero)
      base_source_select_nxt = 1'b0;
    // program fields frozen while the loop runs
    if (wr_prg && !pll_power_on_r) begin
      mul_nxt = wbyte_r[`PBCS_MUL_HI:`PBCS_MUL_LO];
      rng_nxt = wbyte_r[`PBCS_RNG_HI:`PBCS_RNG_LO];
    end
    // a toggle in the clearing cycle keeps the flag set
    if (lock_tg)
      lock_change_flag_nxt = 1'b1;
    else if (rd_ctl)
      lock_change_flag_nxt = 1'b0;
  end

  // control fields and interlocks, checked against the current state
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pll_power_on_r       <= 1'b1;
      base_source_select_r <= 1'b0;
      irq_enable_r         <= 1'b0;
      lock_change_flag_r   <= 1'b0;
      auto_bw_r            <= 1'b0;
      acq_manual_r         <= 1'b0;
      mul_r                <= `PBCS_MUL_RST;
      rng_r                <= `PBCS_RNG_RST;
    end else begin
      pll_power_on_r       <= pll_power_on_nxt;
      base_source_select_r <= base_source_select_nxt;
      lock_change_flag_r   <= lock_change_flag_nxt;
      mul_r                <= mul_nxt;
      rng_r                <= rng_nxt;
      if (wr_ctl && auto_bw_r)
        irq_enable_r <= wbyte_r[`PBCS_CTL_IE];
      if (wr_bw) begin
        auto_bw_r <= wbyte_r[`PBCS_BW_AUTO];
        if (!auto_bw_r)
          acq_manual_r <= wbyte_r[`PBCS_BW_ACQ];
        if (!wbyte_r[`PBCS_BW_AUTO])
          irq_enable_r <= 1'b0;
      end
    end
  end

  // analog side controls
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pll_enable_out <= 1'b0;
      fb_divide_out  <= `PBCS_NIB_ONE;
      range_out      <= `PBCS_RNG_RST;
      acq_track_out  <= 1'b0;
      lock_irq_out   <= 1'b0;
    end else begin
      pll_enable_out <= pll_power_on_r & ~rng_zero & osc_en;
      // zero mapped here so the feedback divider never sees it
      fb_divide_out  <= (mul_r == `PBCS_NIB_ZERO) ? `PBCS_NIB_ONE : mul_r;
      range_out      <= rng_r;
      acq_track_out  <= auto_bw_r ? lock_s : acq_manual_r;
      lock_irq_out   <= lock_change_flag_r & irq_enable_r & auto_bw_r;
    end
  end

  // transition control and dividers
  reg  [2:0] sw_state_r;
  reg        cur_src_r;
  reg  [1:0] edge_cnt_r;

  wire want_vco = base_source_select_r & pll_enable_out;
  wire cur_en   = cur_src_r ? vclk_en : xclk_en;
  wire new_en   = cur_src_r ? xclk_en : vclk_en;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sw_state_r     <= ST_RUN;
      cur_src_r      <= 1'b0;
      edge_cnt_r     <= 2'h0;
      base_clock_out <= 1'b0;
      bus_clock_out  <= 1'b0;
    end else begin
      case (sw_state_r)
        ST_RUN: begin
          if (want_vco != cur_src_r) begin
            sw_state_r <= ST_OLD;
            edge_cnt_r <= 2'h0;
          end else if (cur_en) begin
            base_clock_out <= ~base_clock_out;
            if (!base_clock_out)
              bus_clock_out <= ~bus_clock_out;
          end
        end
        // output held in both wait states; halves only ever stretch
        ST_OLD: begin
          if (cur_en || (cur_src_r && !pll_enable_out))
            edge_cnt_r <= edge_cnt_r + 2'h1;
          if (edge_cnt_r == `PBCS_SW_EDGES) begin
            sw_state_r <= ST_NEW;
            edge_cnt_r <= 2'h0;
          end
        end
        ST_NEW: begin
          // a vco switched off mid-change is timed by clk_sys, never waited on
          if (new_en || (!cur_src_r && !pll_enable_out))
            edge_cnt_r <= edge_cnt_r + 2'h1;
          if (edge_cnt_r == `PBCS_SW_EDGES) begin
            sw_state_r <= ST_RUN;
            cur_src_r  <= ~cur_src_r;
          end
        end
        default: sw_state_r <= ST_RUN;
      endcase
    end
  end

endmodule // pbcs_top

`default_nettype wire

// file: test/pbcs_assertions.sv
/* checker for pbcs_top outputs and bus answers
   bound from the bench top; ports named as the top's */
`timescale 1ns/10ps
`default_nettype none
module pbcs_chk (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // clock outputs and pll controls
  input wire logic       base_clock_out,
  input wire logic       bus_clock_out,
  input wire logic       pll_enable_out,
  input wire logic [3:0] fb_divide_out,
  input wire logic [3:0] range_out,
  // bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_mul; fb_divide_out != 4'h0; endproperty
  a_mul: assert property (p_mul) else $error("zero multiplier out");
  property p_rng; range_out == 4'h0 ##1 range_out == 4'h0 |-> !pll_enable_out; endproperty
  a_rng: assert property (p_rng) else $error("pll on with zero range");
  property p_hold;
    pll_enable_out ##1 pll_enable_out |-> $stable(range_out) && $stable(fb_divide_out);
  endproperty
  a_hold: assert property (p_hold) else $error("program moved while on");
  property p_pulse; $changed(base_clock_out) |=> $stable(base_clock_out) [*3]; endproperty
  a_pulse: assert property (p_pulse) else $error("short base pulse");
  property p_bus; $rose(base_clock_out) |-> ##[0:2] $changed(bus_clock_out); endproperty
  a_bus: assert property (p_bus) else $error("bus clock missed edge");
  property p_busq; $changed(bus_clock_out) |-> base_clock_out; endproperty
  a_busq: assert property (p_busq) else $error("bus clock off base rise");
  property p_wr;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid |-> ##2 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("late write answer");
  property p_rd; s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("late read answer");
  c_wr: cover property (s_axi_bvalid);
  c_rd: cover property (s_axi_rvalid);
  c_bus: cover property ($changed(bus_clock_out));
endmodule // pbcs_chk
`default_nettype wire

// file: test/pbcs_partner.sv
/* far side: free-running crystal and vco sources, oscillator enable
   both periods stay above four clk_sys periods */
`timescale 1ns/10ps
`default_nettype none
module pbcs_partner (
  // sources and enable
  output logic crystal_ref_clock,
  output logic vco_clock,
  output logic osc_enable_in
);
  initial begin
    crystal_ref_clock = 1'b0;
    vco_clock = 1'b0;
    osc_enable_in = 1'b1;
  end
  always #100 crystal_ref_clock = ~crystal_ref_clock;
  // odd half period keeps vco unrelated to clk_sys
  always #63 vco_clock = ~vco_clock;
endmodule // pbcs_partner
`default_nettype wire

// file: test/test_pll_base_clock_selector.sv
/* self-checking bench for pbcs_top with axi4-lite tasks
   partner supplies source clocks; periods 10 and 6.3 cycles */
`timescale 1ns/10ps
`default_nettype none
module test_pll_base_clock_selector;
  logic        clk_sys, rst_b, lock, stop_req, xclk, vclk, osc;
  logic        base, bus, irq, pll_en, acq, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
  logic [3:0]  fbd, rng, awa, ara;
  logic [31:0] wd, rdat, lfsr, v;
  logic [1:0]  bresp, rresp, rsp;
  int          err_count, checked, cyc;
  // crystal of the partner in kHz, nominal centre in 100 Hz units
  localparam int XTAL_KHZ  = 5000;
  localparam int NOM_HZ100 = 49152;
  pbcs_partner i_far (.crystal_ref_clock(xclk), .vco_clock(vclk), .osc_enable_in(osc));
  pbcs_top i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .crystal_ref_clock(xclk),
    .vco_clock(vclk), .pll_lock_in(lock), .osc_enable_in(osc), .stop_req(stop_req),
    .base_clock_out(base), .bus_clock_out(bus), .lock_irq_out(irq),
    .pll_enable_out(pll_en), .fb_divide_out(fbd), .range_out(rng), .acq_track_out(acq),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr));
  always #10 clk_sys = ~clk_sys;
  function automatic logic [31:0] nx(input logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction
  function automatic logic [3:0] mul_exp(input logic [3:0] m);
    return (m == 4'h0) ? 4'h1 : m;
  endfunction
  // software side: multiplier and range from a target bus rate in kHz
  function automatic logic [7:0] prog_for(input int bus_khz);
    int m;
    int l;
    m = (4 * bus_khz + XTAL_KHZ / 2) / XTAL_KHZ;
    l = (m * XTAL_KHZ * 10 + NOM_HZ100 / 2) / NOM_HZ100;
    return {m[3:0], l[3:0]};
  endfunction
  function automatic logic range_ok(input logic [3:0] m, l);
    int d;
    d = int'(l) * NOM_HZ100 - int'(m) * XTAL_KHZ * 10;
    return (d <= NOM_HZ100 / 2) && (-d <= NOM_HZ100 / 2);
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do @(posedge clk_sys); while (!(awr && wr_));
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge clk_sys); while (!bv);
    br <= 1'b0;
    chk("bresp", bresp, 32'h0);
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    rsp = rresp;
    chk(n, rdat, e);
    @(posedge clk_sys);
  endtask
  // cycles between base toggles once the source change settled
  task automatic per(input int e);
    logic t;
    int n;
    repeat (90) @(posedge clk_sys);
    t = base;
    do @(posedge clk_sys); while (base === t);
    t = base;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (base === t && n < 40);
    chk("toggle", n >= e - 1 && n <= e + 1, 1);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 8000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    {clk_sys, rst_b, lock, stop_req, awv, wv, br, arv, rr} = '0;
    {awa, ara, wd} = '0;
    lfsr = 32'h0084;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(4'h0, 32'h2f, "ctrl");
    rd(4'h8, 32'h66, "prog");
    chk("fbd", fbd, 6);
    wr(4'h8, 32'h12);
    rd(4'h8, 32'h66, "prog on");
    wr(4'h0, 32'h30);
    rd(4'h0, 32'h3f, "sel");
    per(6);
    wr(4'h0, 32'h00);
    rd(4'h0, 32'h2f, "one write");
    wr(4'h0, 32'h00);
    rd(4'h0, 32'h0f, "off");
    per(10);
    wr(4'h0, 32'h10);
    rd(4'h0, 32'h0f, "sel off");
    $display("test interlock done");
    for (int i = 0; i < 6; i++) begin
      lfsr = nx(lfsr);
      v = (i == 0) ? 32'h0 : {24'h0, lfsr[7:0]};
      wr(4'h8, v);
      rd(4'h8, v, "prog");
      chk("mul", fbd, mul_exp(v[7:4]));
      chk("rng", rng, v[3:0]);
    end
    v = {24'h0, prog_for(10000)};
    wr(4'h8, v);
    rd(4'h8, 32'h88, "derived");
    chk("centre", range_ok(v[7:4], v[3:0]), 1);
    wr(4'h8, 32'h60);
    wr(4'h0, 32'h20);
    wr(4'h0, 32'h30);
    rd(4'h0, 32'h2f, "rng zero");
    chk("pll_en", pll_en, 0);
    wr(4'h0, 32'h00);
    wr(4'h8, 32'h66);
    wr(4'h0, 32'h20);
    wr(4'h0, 32'h30);
    stop_req <= 1'b1;
    @(posedge clk_sys);
    stop_req <= 1'b0;
    rd(4'h0, 32'h2f, "stop");
    wr(4'h0, 32'h10);
    rd(4'h0, 32'h0f, "off and sel");
    rd(4'hc, 32'h0, "unmapped");
    chk("resp", rsp, 2);
    $display("test program done");
    wr(4'h4, 32'h80);
    wr(4'h0, 32'ha0);
    lock <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk("irq", irq, 1);
    chk("acq", acq, 1);
    rd(4'h0, 32'hef, "flag");
    repeat (2) @(posedge clk_sys);
    chk("irq clr", irq, 0);
    $display("test interrupt done");
    give_verdict();
  end
endmodule // test_pll_base_clock_selector
bind pbcs_top pbcs_chk u_chk (.clk_sys, .rst_b, .base_clock_out, .bus_clock_out,
  .pll_enable_out, .fb_divide_out, .range_out, .s_axi_awvalid, .s_axi_wvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire
